// file: hdl/rscr_regs.sv
// Regulator, signal strength, gain and capacitive sensor readout registers on AXI4-Lite.
// Behaviour
// - Regulator code readout at 2Ch bits 7:4
// - Bit 0 shows regulator current limit
// - Regulator code uses 0.1 V linear steps
// - AM peak code held until reception/clear
// - PM peak code held until reception/clear
// - Strength code monotonic, roughly logarithmic
// - AM combined gain reduction at 2Eh 7:4
// - PM combined gain reduction at 2Eh 3:0
// - Manual trim 2Fh bits 7:3, reset zero
// - Zero manual trim selects automatic calibration
// - Bits 2:0 select capacitive sensor gain
// - Calibrated trim readout at 30h 7:3
// - Bit 2 set when calibration completes
// - Bit 1 set when calibration fails
// - Mode bit picks adjust or host code
`include "rscr_cfg.svh"
module rscr_regs
   import rscr_pkg::*;
(
   // Clock and reset.
   input  wire logic        REF_CLK,
   input  wire logic        RST_B,
   // AXI4-Lite write address and data.
   input  wire logic [9:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   // AXI4-Lite write response.
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   // AXI4-Lite read.
   input  wire logic [9:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Analog and sequencer status.
   input  wire logic        ADJ_DONE,
   input  wire logic [3:0]  ADJ_CODE,
   input  wire logic        CURRENT_LIMIT,
   input  wire logic        RX_START,
   input  wire logic        AM_STRENGTH_VALID,
   input  wire logic [3:0]  AM_STRENGTH,
   input  wire logic        PM_STRENGTH_VALID,
   input  wire logic [3:0]  PM_STRENGTH,
   input  wire logic [3:0]  AM_GAIN_CUT,
   input  wire logic [3:0]  PM_GAIN_CUT,
   input  wire logic        CAL_DONE,
   input  wire logic        CAL_FAIL,
   input  wire logic [4:0]  CAL_TRIM,
   // Controls to the analog front end and the interrupt request.
   output logic [3:0]       REG_CODE,
   output logic [4:0]       CS_TRIM,
   output logic             CS_AUTO_CAL,
   output logic [2:0]       CS_GAIN,
   output logic             CAL_START,
   output logic             IRQ
);
   // Registered state and its next value.
   rscr_state_t s_r;
   rscr_state_t s_nxt;
   logic        wr_fire;
   logic [7:0]  wbyte;
   logic [7:0]  rd_idx;
   // Sticky status events, clears and next values, one bit per flag.
   logic [3:0]  irq_ev;
   logic [3:0]  irq_clr;
   logic [3:0]  irq_keep;

   // Byte lane 0 carries the 8-bit registers; other lanes are ignored.
   function automatic logic [7:0] lane0(input logic [31:0] d, input logic [3:0] be,
                                        input logic [7:0] old);
      if (be[0]) begin
         lane0 = d[7:0];
      end else begin
         lane0 = old;
      end
   endfunction

   // Registers sit on word addresses, so the two low address bits are dropped.
   function automatic logic [7:0] idx_of(input logic [9:0] a);
      idx_of = a[9:2];
   endfunction

   // Only mapped indices answer OKAY; anything else gets a slave error.
   function automatic logic known_idx(input logic [7:0] i);
      if (i == `RSCR_IDX_REG_CTRL) begin
         known_idx = 1'b1;
      end else if (i == `RSCR_IDX_REG_READOUT) begin
         known_idx = 1'b1;
      end else if (i == `RSCR_IDX_STRENGTH) begin
         known_idx = 1'b1;
      end else if (i == `RSCR_IDX_GAIN_STATE) begin
         known_idx = 1'b1;
      end else if (i == `RSCR_IDX_CS_SETUP) begin
         known_idx = 1'b1;
      end else if (i == `RSCR_IDX_CS_RESULT) begin
         known_idx = 1'b1;
      end else if (i == `RSCR_IDX_COMMAND) begin
         known_idx = 1'b1;
      end else if (i == `RSCR_IDX_IRQ_STATUS) begin
         known_idx = 1'b1;
      end else if (i == `RSCR_IDX_IRQ_MASK) begin
         known_idx = 1'b1;
      end else begin
         known_idx = 1'b0;
      end
   endfunction

   // Codes are monotonic in amplitude, so the largest code seen is the peak.
   function automatic logic [3:0] peak_of(input logic [3:0] old, input logic vld,
                                          input logic [3:0] code);
      if (vld && code > old) begin
         peak_of = code;
      end else begin
         peak_of = old;
      end
   endfunction

   // Read value of one register; reserved bits read zero except 2Bh bits 2:0, which read back as written; the command register reads zero.
   function automatic logic [7:0] read_byte(input logic [7:0] i, input rscr_state_t s);
      if (i == `RSCR_IDX_REG_CTRL) begin
         // Mode bit over the host regulator code.
         read_byte = s.reg_ctrl;
      end else if (i == `RSCR_IDX_REG_READOUT) begin
         // Adjust result over the live current limit flag.
         read_byte = {s.adj_code, 3'b000, s.ilim};
      end else if (i == `RSCR_IDX_STRENGTH) begin
         // Held peak codes of both demodulator channels.
         read_byte = {s.am_peak, s.pm_peak};
      end else if (i == `RSCR_IDX_GAIN_STATE) begin
         // Present gain reduction totals of both channels.
         read_byte = {s.am_cut, s.pm_cut};
      end else if (i == `RSCR_IDX_CS_SETUP) begin
         // Manual trim over the sensor gain select.
         read_byte = s.cs_setup;
      end else if (i == `RSCR_IDX_CS_RESULT) begin
         // Calibrated trim over the end and error flags.
         read_byte = {s.cs_trim, s.cal_end, s.cal_err, 1'b0};
      end else if (i == `RSCR_IDX_IRQ_STATUS) begin
         // Sticky event flags.
         read_byte = {4'h0, s.irq_status};
      end else if (i == `RSCR_IDX_IRQ_MASK) begin
         // Interrupt enables of the same layout.
         read_byte = {4'h0, s.irq_mask};
      end else begin
         read_byte = 8'h00;
      end
   endfunction

   // Both halves of a write are held and the response slot is free.
   assign wr_fire = s_r.wst == RSCR_W_IDLE && s_r.aw_got && s_r.w_got;
   assign wbyte   = lane0(s_r.wdata, s_r.wstrb, 8'h00);
   assign rd_idx  = idx_of(S_AXI_ARADDR);

   // Event sources; the current limit flag fires once per rise.
   assign irq_ev[`RSCR_IRQ_CAL_END]  = CAL_DONE;
   assign irq_ev[`RSCR_IRQ_CAL_ERR]  = CAL_FAIL;
   assign irq_ev[`RSCR_IRQ_ILIM]     = CURRENT_LIMIT && !s_r.ilim;
   assign irq_ev[`RSCR_IRQ_ADJ_DONE] = ADJ_DONE;
   // A one written to the status register clears that flag.
   assign irq_clr = (wr_fire && s_r.aw_idx == `RSCR_IDX_IRQ_STATUS) ? wbyte[3:0] : 4'h0;

   // Each flag holds until cleared; an event in the clearing cycle wins.
   for (genvar b = 0; b < `RSCR_IRQ_W; b++) begin : g_sticky
      assign irq_keep[b] = irq_ev[b] || (s_r.irq_status[b] && !irq_clr[b]);
   end

   always_comb begin
      logic       clr_strength;
      logic       start_cal;
      logic [7:0] rv;
      clr_strength = 1'b0;
      start_cal = 1'b0;
      rv = 8'h00;
      s_nxt = s_r;
      s_nxt.cal_start = 1'b0;

      // Write channel: address and data taken in either order.
      // Ready is withheld while a response still waits for the host.
      if (S_AXI_AWVALID && !s_r.aw_got && s_r.wst == RSCR_W_IDLE) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_idx = idx_of(S_AXI_AWADDR);
      end
      if (S_AXI_WVALID && !s_r.w_got && s_r.wst == RSCR_W_IDLE) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = S_AXI_WDATA;
         s_nxt.wstrb = S_AXI_WSTRB;
      end
      case (s_r.wst)
         RSCR_W_IDLE: begin
            if (wr_fire) begin
               s_nxt.aw_got = 1'b0;
               s_nxt.w_got = 1'b0;
               s_nxt.bvalid = 1'b1;
               if (known_idx(s_r.aw_idx)) begin
                  s_nxt.bresp = `RSCR_RESP_OKAY;
               end else begin
                  s_nxt.bresp = `RSCR_RESP_SLVERR;
               end
               s_nxt.wst = RSCR_W_RESP;
            end
         end
         // The response stands until the host takes it.
         RSCR_W_RESP: begin
            if (S_AXI_BREADY) begin
               s_nxt.bvalid = 1'b0;
               s_nxt.wst = RSCR_W_IDLE;
            end
         end
         default: s_nxt.wst = RSCR_W_IDLE;
      endcase

      // Register writes; readout registers fall through untouched.
      if (wr_fire) begin
         if (s_r.aw_idx == `RSCR_IDX_REG_CTRL) begin
            s_nxt.reg_ctrl = lane0(s_r.wdata, s_r.wstrb, s_r.reg_ctrl);
         end else if (s_r.aw_idx == `RSCR_IDX_CS_SETUP) begin
            s_nxt.cs_setup = lane0(s_r.wdata, s_r.wstrb, s_r.cs_setup);
         end else if (s_r.aw_idx == `RSCR_IDX_COMMAND) begin
            // Command strobes act once and are not stored.
            clr_strength = wbyte[`RSCR_CMD_CLR_STRENGTH];
            start_cal = wbyte[`RSCR_CMD_START_CAL];
         end else if (s_r.aw_idx == `RSCR_IDX_IRQ_MASK) begin
            s_nxt.irq_mask = wbyte[3:0];
         end
      end

      // The adjust result is kept until the next ADJ_DONE pulse.
      if (ADJ_DONE) begin
         s_nxt.adj_code = ADJ_CODE;
      end
      s_nxt.ilim = CURRENT_LIMIT;

      // A new reception or a clear command wins over a sample in the same cycle.
      if (RX_START || clr_strength) begin
         s_nxt.am_peak = 4'h0;
         s_nxt.pm_peak = 4'h0;
      end else begin
         s_nxt.am_peak = peak_of(s_r.am_peak, AM_STRENGTH_VALID, AM_STRENGTH);
         s_nxt.pm_peak = peak_of(s_r.pm_peak, PM_STRENGTH_VALID, PM_STRENGTH);
      end
      s_nxt.am_cut = AM_GAIN_CUT;
      s_nxt.pm_cut = PM_GAIN_CUT;

      // Starting a calibration clears the result flags; a finish in that cycle wins.
      if (start_cal) begin
         s_nxt.cal_start = 1'b1;
         s_nxt.cal_end = 1'b0;
         s_nxt.cal_err = 1'b0;
      end
      if (CAL_DONE) begin
         s_nxt.cal_end = 1'b1;
         s_nxt.cs_trim = CAL_TRIM;
      end
      if (CAL_FAIL) begin
         s_nxt.cal_err = 1'b1;
      end

      // Sticky events and the level interrupt.
      s_nxt.irq_status = irq_keep;
      s_nxt.irq = |(s_nxt.irq_status & s_nxt.irq_mask);

      // Read channel; a new read is taken once the previous answer is accepted.
      if (s_r.rvalid && S_AXI_RREADY) begin
         s_nxt.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && !s_r.rvalid) begin
         rv = read_byte(rd_idx, s_r);
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = {24'h00_0000, rv};
         if (known_idx(rd_idx)) begin
            s_nxt.rresp = `RSCR_RESP_OKAY;
         end else begin
            s_nxt.rresp = `RSCR_RESP_SLVERR;
         end
      end

      // Outputs are registered copies of what the next state implies.
      s_nxt.awready = !s_nxt.aw_got && s_nxt.wst == RSCR_W_IDLE;
      s_nxt.wready = !s_nxt.w_got && s_nxt.wst == RSCR_W_IDLE;
      s_nxt.arready = !s_nxt.rvalid;
      // Host-written code overrides the adjust result when the mode bit is set.
      if (s_nxt.reg_ctrl[`RSCR_REG_MODE_BIT]) begin
         s_nxt.reg_code = s_nxt.reg_ctrl[6:3];
      end else begin
         s_nxt.reg_code = s_nxt.adj_code;
      end
      s_nxt.cs_auto_cal = s_nxt.cs_setup[7:3] == 5'b0_0000;
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_r <= '0;
         s_r.cs_setup <= `RSCR_CS_SETUP_RST;
         // Ready outputs and the automatic calibration flag leave reset high.
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
         s_r.cs_auto_cal <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Every output is a register or a slice of one.
   assign S_AXI_AWREADY = s_r.awready;
   assign S_AXI_WREADY  = s_r.wready;
   assign S_AXI_BVALID  = s_r.bvalid;
   assign S_AXI_BRESP   = s_r.bresp;
   assign S_AXI_ARREADY = s_r.arready;
   assign S_AXI_RVALID  = s_r.rvalid;
   assign S_AXI_RDATA   = s_r.rdata;
   assign S_AXI_RRESP   = s_r.rresp;
   assign REG_CODE    = s_r.reg_code;
   assign CS_TRIM     = s_r.cs_setup[7:3];
   assign CS_AUTO_CAL = s_r.cs_auto_cal;
   assign CS_GAIN     = s_r.cs_setup[2:0];
   assign CAL_START   = s_r.cal_start;
   assign IRQ         = s_r.irq;
endmodule

// file: hdl/rscr_cfg.svh
// Register offsets, field positions, reset values and bus responses of the readout block.
`ifndef RSCR_CFG_SVH
`define RSCR_CFG_SVH
// Printed offsets are not all multiples of four: they are indices, byte address = 4 * index.
`define RSCR_IDX_REG_CTRL     8'h2B
`define RSCR_IDX_REG_READOUT  8'h2C
`define RSCR_IDX_STRENGTH     8'h2D
`define RSCR_IDX_GAIN_STATE   8'h2E
`define RSCR_IDX_CS_SETUP     8'h2F
`define RSCR_IDX_CS_RESULT    8'h30
`define RSCR_IDX_COMMAND      8'h40
`define RSCR_IDX_IRQ_STATUS   8'h41
`define RSCR_IDX_IRQ_MASK     8'h42
`define RSCR_REG_MODE_BIT     7
`define RSCR_ILIM_BIT         0
`define RSCR_CAL_END_BIT      2
`define RSCR_CAL_ERR_BIT      1
`define RSCR_CMD_CLR_STRENGTH 0
`define RSCR_CMD_START_CAL    1
`define RSCR_IRQ_CAL_END      0
`define RSCR_IRQ_CAL_ERR      1
`define RSCR_IRQ_ILIM         2
`define RSCR_IRQ_ADJ_DONE     3
`define RSCR_IRQ_W            4
`define RSCR_CS_SETUP_RST     8'h00
`define RSCR_RESP_OKAY        2'b00
`define RSCR_RESP_SLVERR      2'b10
`endif

// file: hdl/rscr_pkg.sv
// Types shared by the readout register block.
package rscr_pkg;
   typedef enum logic [1:0] {
      RSCR_W_IDLE,
      RSCR_W_RESP
   } rscr_wstate_t;
   typedef struct packed {
      rscr_wstate_t wst;
      logic         aw_got;
      logic         w_got;
      logic [7:0]   aw_idx;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
      logic [7:0]   reg_ctrl;
      logic [3:0]   adj_code;
      logic         ilim;
      logic [3:0]   am_peak;
      logic [3:0]   pm_peak;
      logic [3:0]   am_cut;
      logic [3:0]   pm_cut;
      logic [7:0]   cs_setup;
      logic [4:0]   cs_trim;
      logic         cal_end;
      logic         cal_err;
      logic         cal_start;
      logic [3:0]   irq_status;
      logic [3:0]   irq_mask;
      logic         irq;
      logic         awready;
      logic         wready;
      logic         arready;
      logic [3:0]   reg_code;
      logic         cs_auto_cal;
   } rscr_state_t;
endpackage

// file: testbench/rscr_props.sv
// Concurrent checks on the readout block ports.
module rscr_props (
   // Clock and reset.
   input wire logic        REF_CLK,
   input wire logic        RST_B,
   // Bus handshakes.
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   // Front end controls.
   input wire logic [4:0]  CS_TRIM,
   input wire logic        CS_AUTO_CAL,
   input wire logic        CAL_START
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (!RST_B);
   sequence rd_taken;
      S_AXI_ARVALID && S_AXI_ARREADY;
   endsequence
   sequence rd_stall;
      S_AXI_RVALID && !S_AXI_RREADY;
   endsequence
   rd_answer_a: assert property (rd_taken |=> S_AXI_RVALID)
      else $error("Read answer late.");
   rd_hold_a: assert property (rd_stall |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("Read data dropped.");
   rd_release_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("Read not released.");
   ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
      else $error("Second read taken.");
   wr_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("Write answer dropped.");
   rd_upper_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
      else $error("Upper read bits set.");
   manual_trim_a: assert property (CS_AUTO_CAL == (CS_TRIM == 5'h00))
      else $error("Manual mode with zero trim.");
   cal_pulse_a: assert property ($rose(CAL_START) |=> !CAL_START)
      else $error("Start pulse too long.");
endmodule

bind rscr_regs rscr_props chk_u (.*);

// file: testbench/regulator_signal_capsense_regs_tb.sv
// Self-checking bench for the readout register block.
`include "rscr_cfg.svh"
module regulator_signal_capsense_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        REF_CLK, RST_B, ADJ_DONE, CURRENT_LIMIT, RX_START, CAL_DONE, CAL_FAIL;
   logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
   logic        S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
   logic        AM_STRENGTH_VALID, PM_STRENGTH_VALID, CS_AUTO_CAL, CAL_START, IRQ;
   logic [9:0]  S_AXI_AWADDR, S_AXI_ARADDR;
   logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
   logic [3:0]  S_AXI_WSTRB, ADJ_CODE, AM_STRENGTH, PM_STRENGTH, AM_GAIN_CUT, PM_GAIN_CUT;
   logic [3:0]  REG_CODE;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
   logic [4:0]  CAL_TRIM, CS_TRIM;
   logic [2:0]  CS_GAIN;
   int          bad_count, comparisons, v, a, p, k, t, starts;
   int          gc[5] = '{0, 1, 2, 4, 6};
   rscr_regs dut_u (.*);
   initial begin
      REF_CLK = 1'b0;
      forever #2.5 REF_CLK = ~REF_CLK;
   end
   always @(posedge REF_CLK) if (CAL_START === 1'b1) starts++;
   task test_done;
      $display("mismatches %0d of %0d comparisons", bad_count, comparisons);
      if (bad_count == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Ready is held back a little so that the answer has to stand.
   task automatic bus(input logic w, input logic [7:0] i, input int d);
      int n = 0;
      @(posedge REF_CLK);
      S_AXI_AWADDR <= {i, 2'b00};
      S_AXI_ARADDR <= {i, 2'b00};
      S_AXI_WDATA <= 32'(d);
      S_AXI_WSTRB <= 4'hf;
      S_AXI_AWVALID <= w;
      S_AXI_WVALID <= w;
      S_AXI_ARVALID <= !w;
      do begin
         @(posedge REF_CLK);
         n++;
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
         if (n == 3) S_AXI_BREADY <= w;
         if (n == 3) S_AXI_RREADY <= !w;
      end while (!(w ? S_AXI_BVALID && S_AXI_BREADY : S_AXI_RVALID && S_AXI_RREADY) && n < 40);
      rd = S_AXI_RDATA;
      rsp = w ? S_AXI_BRESP : S_AXI_RRESP;
      S_AXI_BREADY <= 1'b0;
      S_AXI_RREADY <= 1'b0;
      if (n >= 40) begin
         ck("wait", 0, 1);
         test_done;
      end
   endtask
   task rdc(input logic [7:0] i, input int e);
      bus(0, i, 0);
      ck("resp", 0, rsp);
      ck("rdata", e, rd);
   endtask
   initial begin
      {RST_B, ADJ_DONE, CURRENT_LIMIT, RX_START, CAL_DONE, CAL_FAIL, S_AXI_AWVALID} = '0;
      {S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, AM_STRENGTH_VALID} = '0;
      {PM_STRENGTH_VALID, S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
      {ADJ_CODE, AM_STRENGTH, PM_STRENGTH, AM_GAIN_CUT, PM_GAIN_CUT, CAL_TRIM} = '0;
      v = $urandom(32'haeb9);
      repeat (6) @(posedge REF_CLK);
      RST_B <= 1'b1;
      rdc(`RSCR_IDX_CS_SETUP, 0);
      t = $urandom % 16;
      @(posedge REF_CLK) ADJ_DONE <= 1'b1;
      ADJ_CODE <= 4'(t);
      CURRENT_LIMIT <= 1'b1;
      @(posedge REF_CLK) ADJ_DONE <= 1'b0;
      rdc(`RSCR_IDX_REG_READOUT, t * 16 + 1);
      ck("code", t, REG_CODE);
      CURRENT_LIMIT <= 1'b0;
      bus(1, `RSCR_IDX_REG_READOUT, 8'hff);
      rdc(`RSCR_IDX_REG_READOUT, t * 16);
      bus(1, `RSCR_IDX_REG_CTRL, 128 + (15 - t) * 8);
      ck("host", 15 - t, REG_CODE);
      for (t = 0; t < 2; t++) begin
         a = 0;
         p = 0;
         for (k = 0; k < 4; k++) begin
            v = $urandom;
            @(posedge REF_CLK) AM_STRENGTH_VALID <= 1'b1;
            PM_STRENGTH_VALID <= 1'b1;
            AM_STRENGTH <= v[3:0];
            PM_STRENGTH <= v[7:4];
            a = v[3:0] > a ? v[3:0] : a;
            p = v[7:4] > p ? v[7:4] : p;
         end
         @(posedge REF_CLK) AM_STRENGTH_VALID <= 1'b0;
         PM_STRENGTH_VALID <= 1'b0;
         rdc(`RSCR_IDX_STRENGTH, a * 16 + p);
         if (t) bus(1, `RSCR_IDX_COMMAND, 1);
         else begin
            @(posedge REF_CLK) RX_START <= 1'b1;
            @(posedge REF_CLK) RX_START <= 1'b0;
         end
         rdc(`RSCR_IDX_STRENGTH, 0);
      end
      v = $urandom;
      AM_GAIN_CUT <= v[3:0];
      PM_GAIN_CUT <= v[7:4];
      rdc(`RSCR_IDX_GAIN_STATE, v[3:0] * 16 + v[7:4]);
      foreach (gc[k]) begin
         v = (k ? $urandom % 31 + 1 : 0) * 8 + gc[k];
         bus(1, `RSCR_IDX_CS_SETUP, v);
         rdc(`RSCR_IDX_CS_SETUP, v);
         ck("gain", gc[k], CS_GAIN);
         ck("auto", k == 0, CS_AUTO_CAL);
         if (k) ck("trim", v / 8, CS_TRIM);
      end
      bus(1, `RSCR_IDX_IRQ_MASK, 3);
      bus(1, `RSCR_IDX_COMMAND, 2);
      ck("start", 1, starts);
      t = $urandom % 32;
      @(posedge REF_CLK) CAL_DONE <= 1'b1;
      CAL_TRIM <= 5'(t);
      @(posedge REF_CLK) CAL_DONE <= 1'b0;
      rdc(`RSCR_IDX_CS_RESULT, t * 8 + 4);
      ck("irq", 1, IRQ);
      @(posedge REF_CLK) CAL_FAIL <= 1'b1;
      @(posedge REF_CLK) CAL_FAIL <= 1'b0;
      rdc(`RSCR_IDX_CS_RESULT, t * 8 + 6);
      bus(1, `RSCR_IDX_COMMAND, 2);
      ck("start", 2, starts);
      rdc(`RSCR_IDX_CS_RESULT, t * 8);
      bus(1, `RSCR_IDX_IRQ_STATUS, 15);
      bus(1, `RSCR_IDX_IRQ_MASK, 1);
      @(posedge REF_CLK) CAL_FAIL <= 1'b1;
      @(posedge REF_CLK) CAL_FAIL <= 1'b0;
      rdc(`RSCR_IDX_IRQ_STATUS, 2);
      ck("irq", 0, IRQ);
      bus(1, 8'h3f, 0);
      ck("bresp", 2, rsp);
      test_done;
   end
endmodule
